// ---- verilog/amr_readout.sv ----
// Analog monitor readout: APB window onto the on-chip converter results.
// Assumes conv arrives on clk from the macro; pair levels are steered by the macro mux.
// What this block does
// - Every result sits in bits 15:0 of the 32-bit register word.
// - Results are MSB-justified so the 12 accurate bits are at the top of the field.
// - Offset 0x200 returns the latest die temperature result, read-only, no reset value.
// - Any write to offset 0x20C resets the converter macro whatever the data.
// - Offset 0x264 returns the auxiliary input 9 result, zero after reset.
// - Offset 0x274 returns the auxiliary input 13 result, zero after reset.
// - Bits 31:16 have no function; writes are ignored and reads give zero here.
// - Header pair A feeds channel 13 and header pair B feeds channel 9.

// Bus timing
// The slave never stalls, so pready is tied high and every transfer is two cycles.
// Read data is taken from the result registers at the setup edge and held in prdata_ff.
// This means the access phase shows a value that cannot tear, even if a conversion
// lands in the same cycle as the access edge.
// The cost is that a conversion landing during the setup cycle is seen by the next read.
// prdata_ff keeps its value through writes and idle cycles and changes only at a read setup.
// An unmapped read answers with pslverr and zero data; an unmapped write only raises pslverr.
//
// Converter side
// The macro hands over one result per cycle at most, as a valid pulse with a channel code.
// Only the 12 accurate bits cross the interface; the low nibble is made here as zeros.
// A bus write to the dedicated register gives a one-cycle reset pulse the cycle after.
// Back-to-back writes give separate pulses, one per write, with a low cycle between them.
// The written data is dropped on purpose; no register in the window can be written.
//
// Limitations
// The temperature result has no reset, so it reads unknown until the first conversion.
// Software must wait for one temperature conversion before trusting that register.
// The converter reset pulse does not clear the stored results; they keep the last values.
`timescale 1ns/10ps
module amr_readout
	import amr_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire amr_apb_req_s apbReq,
	output logic              pready,
	output logic              pslverr,
	output logic [31:0]       prdata,
	input  wire amr_conv_s    conv,
	output logic              convReset,
	output logic              auxSelPairA
);

	// Result storage, one 16-bit word per channel
	logic [15:0] tempRes_ff;
	logic [15:0] dedicRes_ff;
	logic [15:0] aux9Res_ff;
	logic [15:0] aux13Res_ff;
	logic [31:0] prdata_ff;
	logic        convReset_ff;

	// Address decode for the read setup edge and the access phase
	wire logic access   = apbReq.psel & apbReq.penable;
	wire logic hitTemp  = apbReq.paddr == AMR_OFF_TEMP;
	wire logic hitDedic = apbReq.paddr == AMR_OFF_DEDIC;
	wire logic hitAux9  = apbReq.paddr == AMR_OFF_AUX9;
	wire logic hitAux13 = apbReq.paddr == AMR_OFF_AUX13;
	wire logic hitAny   = hitTemp | hitDedic | hitAux9 | hitAux13;
	wire logic wrDedic  = access & apbReq.pwrite & hitDedic;

	// MSB-justify the 12 accurate bits; low bits stay zero
	wire logic [15:0] justCode = {conv.code, {(AMR_RES_W-AMR_ACC_W){1'b0}}};

	// Read mux; upper half reads zero
	wire logic [15:0] rdField = hitTemp  ? tempRes_ff  :
	                            hitDedic ? dedicRes_ff :
	                            hitAux9  ? aux9Res_ff  :
	                            hitAux13 ? aux13Res_ff : 16'h0000;
	wire logic [31:0] nxt_prdata = {16'h0000, rdField};

	// Capture strobes; only a completed conversion updates a register
	wire logic capTemp  = conv.valid & (conv.chan == AMR_CH_TEMP);
	wire logic capDedic = conv.valid & (conv.chan == AMR_CH_DEDIC);
	wire logic capAux9  = conv.valid & (conv.chan == AMR_CH_AUX9);
	wire logic capAux13 = conv.valid & (conv.chan == AMR_CH_AUX13);

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = access & ~hitAny;
	assign prdata  = prdata_ff;

	// Temperature result has no defined reset, so it needs no reset branch
	always_ff @(posedge clk)
	begin
		if (capTemp)
			tempRes_ff <= justCode;
	end

	// Channel results with reset; bus writes never touch them
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dedicRes_ff <= AMR_RES_RESET;
			aux9Res_ff  <= AMR_RES_RESET;
			aux13Res_ff <= AMR_RES_RESET;
		end
		else
		begin
			if (capDedic)
				dedicRes_ff <= justCode;
			if (capAux9)
				aux9Res_ff <= justCode;
			if (capAux13)
				aux13Res_ff <= justCode;
		end
	end

	// Read data registered in setup so it is valid during the access phase
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			prdata_ff <= 32'h0000_0000;
		else if (apbReq.psel & ~apbReq.penable & ~apbReq.pwrite)
			prdata_ff <= nxt_prdata;
	end

	// One-cycle reset pulse to the macro per write to the dedicated register
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			convReset_ff <= 1'b0;
		else
			convReset_ff <= wrDedic;
	end
	assign convReset = convReset_ff;

	// Pair A is routed to channel 13; pair B to channel 9
	assign auxSelPairA = 1'b1;

	// Write to 0x20C gives one reset pulse next cycle
	dedic_reset_a: assert property (@(posedge clk) disable iff (!rstn)
		wrDedic |=> convReset ##1 !convReset || $past(wrDedic))
		else $error("converter reset pulse missing");

	// No reset pulse without a write
	reset_cause_a: assert property (@(posedge clk) disable iff (!rstn)
		convReset |-> $past(wrDedic))
		else $error("spurious converter reset");

	// Aux 9 captures justified code
	aux9_capture_a: assert property (@(posedge clk) disable iff (!rstn)
		capAux9 |=> aux9Res_ff == {$past(conv.code), 4'h0})
		else $error("aux 9 capture wrong");

	// Aux 13 captures justified code
	aux13_capture_a: assert property (@(posedge clk) disable iff (!rstn)
		capAux13 |=> aux13Res_ff == {$past(conv.code), 4'h0})
		else $error("aux 13 capture wrong");

	// Dedicated result captures justified code
	dedic_capture_a: assert property (@(posedge clk) disable iff (!rstn)
		capDedic |=> dedicRes_ff == {$past(conv.code), 4'h0})
		else $error("dedicated capture wrong");

	// Aux 9 and aux 13 results hold when no conversion for either arrives
	result_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		!capAux9 && !capAux13 |=> $stable(aux9Res_ff) && $stable(aux13Res_ff))
		else $error("result changed without conversion");

	// Aux 9 and dedicated low nibbles always zero
	msb_justify_a: assert property (@(posedge clk) disable iff (!rstn)
		aux9Res_ff[3:0] == 4'h0 && dedicRes_ff[3:0] == 4'h0)
		else $error("result not MSB-justified");

	// Upper half reads zero during access
	upper_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		access |-> prdata[31:16] == 16'h0000)
		else $error("upper bits not zero");

	// Read of aux 13 returns the stored value
	aux13_read_a: assert property (@(posedge clk) disable iff (!rstn)
		access && !apbReq.pwrite && hitAux13 && $past(!capAux13)
		|-> prdata[15:0] == aux13Res_ff)
		else $error("aux 13 read wrong");

	// Read of aux 9 returns the stored value
	aux9_read_a: assert property (@(posedge clk) disable iff (!rstn)
		access && !apbReq.pwrite && hitAux9 && $past(!capAux9)
		|-> prdata[15:0] == aux9Res_ff)
		else $error("aux 9 read wrong");

	// Read of the dedicated input returns the stored value
	dedic_read_a: assert property (@(posedge clk) disable iff (!rstn)
		access && !apbReq.pwrite && hitDedic && $past(!capDedic)
		|-> prdata[15:0] == dedicRes_ff)
		else $error("dedicated read wrong");

	// Read of the temperature returns the stored value
	temp_read_a: assert property (@(posedge clk) disable iff (!rstn)
		access && !apbReq.pwrite && hitTemp && $past(!capTemp)
		|-> prdata[15:0] == tempRes_ff)
		else $error("temperature read wrong");

	// Temperature result captures justified code
	temp_capture_a: assert property (@(posedge clk) disable iff (!rstn)
		capTemp |=> tempRes_ff == {$past(conv.code), 4'h0})
		else $error("temperature capture wrong");

	// Dedicated result holds when no conversion for it arrives
	dedic_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		!capDedic |=> $stable(dedicRes_ff))
		else $error("dedicated result changed without conversion");

	// Aux 13 low nibble always zero
	aux13_justify_a: assert property (@(posedge clk) disable iff (!rstn)
		aux13Res_ff[3:0] == 4'h0)
		else $error("aux 13 result not MSB-justified");

	// Unmapped read answers with an error and zero data
	unmapped_read_a: assert property (@(posedge clk) disable iff (!rstn)
		access && !apbReq.pwrite && !hitAny |-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped read not refused");

	// The dedicated offset never raises an error
	mapped_ok_a: assert property (@(posedge clk) disable iff (!rstn)
		access && apbReq.paddr == AMR_OFF_DEDIC |-> !pslverr)
		else $error("mapped access refused");

	// Read data changes only at a read setup edge
	prdata_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		!(apbReq.psel && !apbReq.penable && !apbReq.pwrite) |=> $stable(prdata))
		else $error("read data changed outside a read setup");

	// Main scenarios
	wr_dedic_c: cover property (@(posedge clk) disable iff (!rstn) wrDedic);
	rd_temp_c:  cover property (@(posedge clk) disable iff (!rstn)
		access && !apbReq.pwrite && hitTemp);
	unmapped_c: cover property (@(posedge clk) disable iff (!rstn) pslverr);
	cap_aux_c:  cover property (@(posedge clk) disable iff (!rstn) capAux9 ##1 capAux13);
	rd_aux9_c:  cover property (@(posedge clk) disable iff (!rstn)
		access && !apbReq.pwrite && hitAux9);

endmodule : amr_readout

// ---- verilog/amr_pkg.sv ----
// Package for the analog monitor readout block: register map, field layout, types.
// Assumes a 32-bit APB master and a converter macro that strobes results per channel.
package amr_pkg;

	// Register byte offsets inside the block window
	localparam logic [11:0] AMR_OFF_TEMP    = 12'h200;
	localparam logic [11:0] AMR_OFF_DEDIC   = 12'h20C;
	localparam logic [11:0] AMR_OFF_AUX9    = 12'h264;
	localparam logic [11:0] AMR_OFF_AUX13   = 12'h274;
	localparam logic [31:0] AMR_BASE_ADDR   = 32'h4BB0_6000;

	// Result field layout
	localparam int          AMR_RES_MSB     = 15;
	localparam int          AMR_RES_W       = 16;
	localparam int          AMR_ACC_W       = 12;
	localparam logic [15:0] AMR_RES_RESET   = 16'h0000;

	// Converter reset pulse length in cycles
	localparam int          AMR_RST_CYCLES  = 1;

	// Channel selector as delivered by the converter macro
	typedef enum logic [1:0]
	{
		AMR_CH_TEMP  = 2'h0,
		AMR_CH_DEDIC = 2'h1,
		AMR_CH_AUX9  = 2'h2,
		AMR_CH_AUX13 = 2'h3
	} amr_chan_e;

	// One completed conversion from the macro
	typedef struct packed
	{
		logic                 valid;
		amr_chan_e            chan;
		logic [AMR_ACC_W-1:0] code;
	} amr_conv_s;

	// APB request from the master
	typedef struct packed
	{
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} amr_apb_req_s;

endpackage : amr_pkg

// ---- test/amr_conv_model.sv ----
// Behavioural converter macro: replays each conversion the bench requests, except one requested while convReset is high.
// Assumes it shares one clock with the readout block.
`timescale 1ns/10ps
module amr_conv_model
	import amr_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rstn,
	input  wire logic      convReset,
	input  wire amr_conv_s req,
	output amr_conv_s      conv
);
	// Idle cycles show a changing pattern, so stale codes cannot pass unnoticed
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			conv <= '0;
		else if (convReset)
			conv <= '0;
		else
			conv <= req.valid ? req : {1'b0, ~conv.chan, ~conv.code};
endmodule : amr_conv_model

// ---- test/amr_readout_test.sv ----
// Self-checking bench for the readout block: APB master, scoreboard, converter model.
// Assumes zero or more wait states; waits on pready under a bound.
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
	$display("[FAIL] %0t got %h want %h", $time, a, e); end end
module amr_readout_test
	import amr_pkg::*;
;
	logic         clk = 0, rstn = 0, prevWrite = 0, pready, pslverr, convReset, auxSelPairA;
	amr_apb_req_s apbReq = '0;
	amr_conv_s    req = '0, conv;
	logic [31:0]  prdata, rnd;
	logic [32:0]  q [$], want;
	logic [11:0]  code;
	logic [11:0]  offs [4] = '{AMR_OFF_TEMP, AMR_OFF_DEDIC, AMR_OFF_AUX9, AMR_OFF_AUX13};
	int           errors = 0, n_compared = 0, cycles = 0;

	always #5 clk = ~clk;
	amr_readout amr_readout_inst (.clk(clk), .rstn(rstn), .apbReq(apbReq), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .conv(conv), .convReset(convReset),
		.auxSelPairA(auxSelPairA));
	amr_conv_model amr_conv_model_inst (.clk(clk), .rstn(rstn), .convReset(convReset),
		.req(req), .conv(conv));

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int t;
		t = 0;
		if (!w) q.push_back(e);
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++t < 20);
		if (t == 20) errors++;
		apbReq <= '0;
		@(posedge clk);
	endtask : apb

	task automatic conv_put(input logic [1:0] ch, input logic [11:0] c);
		req <= '{1'b1, amr_chan_e'(ch), c};
		@(posedge clk);
		req <= '0;
		repeat (3) @(posedge clk);
	endtask : conv_put

	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// Scoreboard; pre-edge values are read, so flop updates at this edge never race
	always @(posedge clk)
	begin
		prevWrite <= apbReq.psel && apbReq.penable && apbReq.pwrite && pready
			&& apbReq.paddr == AMR_OFF_DEDIC;
		`CHK(convReset, prevWrite)
		if (apbReq.psel && apbReq.penable && !apbReq.pwrite && pready === 1'b1)
		begin
			want = q.pop_front();
			`CHK({pslverr, prdata}, want)
		end
		if (++cycles > 3000)
		begin
			errors++;
			summarize();
		end
	end

	// Main sequence
	initial
	begin
		rnd = $urandom(32'h2444);
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 1; i < 4; i++)
			apb(1'b0, offs[i], '0, 33'h0);
		$display("test reset values done");
		repeat (2)
			for (int i = 0; i < 4; i++)
			begin
				code = 12'($urandom);
				conv_put(2'(i), code);
				apb(1'b0, offs[i], '0, {17'h0, code, 4'h0});
			end
		$display("test conversions done");
		code = 12'($urandom);
		conv_put(2'h2, code);
		apb(1'b1, AMR_OFF_AUX9, $urandom, 33'h0);
		repeat (2)
			apb(1'b0, AMR_OFF_AUX9, '0, {17'h0, code, 4'h0});
		$display("test ignored write done");
		apb(1'b1, AMR_OFF_DEDIC, $urandom, 33'h0);
		apb(1'b1, AMR_OFF_DEDIC, $urandom, 33'h0);
		apb(1'b0, 12'h300, '0, {1'b1, 32'h0});
		`CHK(auxSelPairA, 1'b1)
		$display("test converter reset done");
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 1; i < 4; i++)
			apb(1'b0, offs[i], '0, 33'h0);
		$display("test mid-run reset done");
		summarize();
	end
endmodule : amr_readout_test
